// File: smape_defs.vh
// Constants for the SFR area mapping and module page extension block.
// Assumes an 8-bit SFR bus whose SFR addresses lie in 80h..FFh.
`ifndef SMAPE_DEFS_VH
`define SMAPE_DEFS_VH

// ==========================================================
// Addresses on the SFR bus
`define SMAPE_SFR_BASE 8'h80
`define SMAPE_SC0_ADDR 8'h8F
`define SMAPE_PAGE_ADDR 8'hA1
`define SMAPE_PAGED_LO 8'hA2
`define SMAPE_PAGED_HI 8'hA7
`define SMAPE_MDU_LO 8'hB0
`define SMAPE_MDU_HI 8'hB7

// ==========================================================
// System control register fields and reset value
`define SMAPE_SC0_RESET 8'h04
`define SMAPE_SC0_AREA_BIT 0
`define SMAPE_SC0_ONE_BIT 2
`define SMAPE_SC0_INTERRUPT_MODE_BIT_BIT 4

// ==========================================================
// Module page register fields
`define SMAPE_PG_PAGE_MSB 2
`define SMAPE_PG_SLOT_MSB 5
`define SMAPE_PG_SLOT_LSB 4
`define SMAPE_PG_OP_MSB 7
`define SMAPE_PG_OP_LSB 6
`define SMAPE_PG_OP_SAVE 2'h2
`define SMAPE_PG_OP_RESTORE 2'h3
`define SMAPE_PG_RESET 3'h0
`define SMAPE_PG_SLOTS 4

`endif

// File: smape_sysctl.v
// System control register zero: area select, interrupt mode, fixed bits.
// Assumes the caller qualifies the write strobe with the clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "smape_defs.vh"

module smape_sysctl
(
  input wire clk,
  input wire rst_b,
  input wire wrEn,
  input wire [7:0] wrData,
  output wire sfrAreaSelect,
  output wire interruptModeBit,
  output wire [7:0] rdData
);

  localparam [7:0] SC0_RST = `SMAPE_SC0_RESET;

  reg area_q;
  reg interrupt_mode_bit_q;

  // ==========================================================
  // Writable bits
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      area_q <= SC0_RST[`SMAPE_SC0_AREA_BIT];
      interrupt_mode_bit_q <= SC0_RST[`SMAPE_SC0_INTERRUPT_MODE_BIT_BIT];
    end
    else if (wrEn)
    begin
      area_q <= wrData[`SMAPE_SC0_AREA_BIT];
      interrupt_mode_bit_q <= wrData[`SMAPE_SC0_INTERRUPT_MODE_BIT_BIT];
    end
  end

  assign sfrAreaSelect = area_q;
  assign interruptModeBit = interrupt_mode_bit_q;
  // Bit 2 reads one, bits 7..5, 3 and 1 read zero
  assign rdData = {3'h0, interrupt_mode_bit_q, 1'b0, 1'b1, 1'b0, area_q};

endmodule // smape_sysctl
`default_nettype wire

// File: smape_page_reg.v
// Module page register with four save/restore slots.
// Assumes the caller qualifies the write strobe with the clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "smape_defs.vh"

module smape_page_reg
#(
  parameter PAGE_W = 3
)
(
  input wire clk,
  input wire rst_b,
  input wire wrEn,
  input wire [7:0] wrData,
  output wire [PAGE_W-1:0] page,
  output wire [7:0] rdData
);

  reg [PAGE_W-1:0] page_q;
  reg [PAGE_W-1:0] slot_q [0:`SMAPE_PG_SLOTS-1];
  wire [1:0] op = wrData[`SMAPE_PG_OP_MSB:`SMAPE_PG_OP_LSB];
  wire [1:0] slotSel = wrData[`SMAPE_PG_SLOT_MSB:`SMAPE_PG_SLOT_LSB];
  genvar gi;

  // ==========================================================
  // Current page
  always @(posedge clk)
  begin
    if (!rst_b)
      page_q <= `SMAPE_PG_RESET;
    else if (wrEn)
    begin
      if (op == `SMAPE_PG_OP_RESTORE)
        page_q <= slot_q[slotSel];
      else
        page_q <= wrData[PAGE_W-1:0];
    end
  end

  // ==========================================================
  // Storage slots, old page copied in on a save
  generate
    for (gi = 0; gi < `SMAPE_PG_SLOTS; gi = gi + 1)
    begin : gSlot
      always @(posedge clk)
      begin
        if (!rst_b)
          slot_q[gi] <= `SMAPE_PG_RESET;
        else if (wrEn && op == `SMAPE_PG_OP_SAVE && slotSel == gi)
          slot_q[gi] <= page_q;
      end
    end
  endgenerate

  assign page = page_q;
  assign rdData = {{(8-PAGE_W){1'b0}}, page_q};

endmodule // smape_page_reg
`default_nettype wire

// File: smape_sfr_map.v
// SFR area mapping and paged address extension in front of the peripherals.
// Assumes one CPU request at a time; a read to a peripheral is answered
// combinationally on periphRdData in the cycle the forward strobe is high.
`timescale 1ns/1ps
`default_nettype none
`include "smape_defs.vh"

module smape_sfr_map
#(
  parameter PAGE_W = 3
)
(
  input wire clk,
  input wire rst_b,
  input wire clkEn,
  input wire [7:0] cpuAddr,
  input wire [7:0] cpuWrData,
  input wire cpuWrEn,
  input wire cpuRdEn,
  output wire cpuBusy,
  output wire [7:0] cpuRdData,
  output wire cpuRdValid,
  output wire sfrAreaSelect,
  output wire interruptModeBit,
  output wire [PAGE_W-1:0] modulePage,
  output wire fwdWr,
  output wire fwdRd,
  output wire [3:0] fwdTarget,
  output wire [7:0] fwdIndex,
  output wire [PAGE_W+7:0] fwdExtAddr,
  output wire [7:0] fwdWrData,
  input wire [7:0] periphRdData
);

  // ==========================================================
  // Target codes, one-hot
  localparam [3:0] TGT_STD = 4'h1;
  localparam [3:0] TGT_MAP = 4'h2;
  localparam [3:0] TGT_MDU = 4'h4;
  localparam [3:0] TGT_PAGED = 4'h8;

  // Read answer states, one-hot
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // Inclusive address range check
  function inRange;
    input [7:0] addr;
    input [7:0] lo;
    input [7:0] hi;
    begin
      inRange = (addr >= lo) && (addr <= hi);
    end
  endfunction

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] rdData_q;
  reg [7:0] rdData_d;
  reg rdValid_q;
  reg rdValid_d;
  reg fwdWr_q;
  reg fwdRd_q;
  reg [3:0] fwdTarget_q;
  reg [7:0] fwdIndex_q;
  reg [PAGE_W+7:0] fwdExtAddr_q;
  reg [7:0] fwdWrData_q;

  wire [7:0] sc0RdData;
  wire [7:0] pageRdData;
  wire areaSel;
  wire [PAGE_W-1:0] curPage;

  // ==========================================================
  // Request decode
  wire idle = (state_q == ST_IDLE);
  wire isSfr = cpuAddr[7];
  wire wrReq = clkEn && idle && cpuWrEn && isSfr;
  wire rdReq = clkEn && idle && cpuRdEn && !cpuWrEn;
  wire hitSc0 = (cpuAddr == `SMAPE_SC0_ADDR);
  wire hitPage = !areaSel && (cpuAddr == `SMAPE_PAGE_ADDR);
  wire hitPaged = !areaSel && inRange(cpuAddr, `SMAPE_PAGED_LO, `SMAPE_PAGED_HI);
  wire hitMdu = areaSel && inRange(cpuAddr, `SMAPE_MDU_LO, `SMAPE_MDU_HI);
  wire hitLocal = hitSc0 || hitPage;

  reg [3:0] target;
  always @*
  begin
    if (hitPaged)
      target = TGT_PAGED;
    else if (hitMdu)
      target = TGT_MDU;
    else if (areaSel)
      target = TGT_MAP;
    else
      target = TGT_STD;
  end

  // ==========================================================
  // Local registers
  smape_sysctl uSysctl
  (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrReq && hitSc0),
    .wrData(cpuWrData),
    .sfrAreaSelect(areaSel),
    .interruptModeBit(interruptModeBit),
    .rdData(sc0RdData)
  );

  smape_page_reg #(.PAGE_W(PAGE_W)) uPage
  (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrReq && hitPage),
    .wrData(cpuWrData),
    .page(curPage),
    .rdData(pageRdData)
  );

  // ==========================================================
  // Read answer sequencing
  always @*
  begin
    state_d = state_q;
    rdData_d = rdData_q;
    rdValid_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (rdReq)
        begin
          if (!isSfr)
          begin
            rdData_d = 8'h00;
            rdValid_d = 1'b1;
          end
          else if (hitSc0)
          begin
            rdData_d = sc0RdData;
            rdValid_d = 1'b1;
          end
          else if (hitPage)
          begin
            rdData_d = pageRdData;
            rdValid_d = 1'b1;
          end
          else
            state_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        rdData_d = periphRdData;
        rdValid_d = 1'b1;
        state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // ==========================================================
  // Forwarding to peripherals
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      fwdWr_q <= 1'b0;
      fwdRd_q <= 1'b0;
      fwdTarget_q <= 4'h0;
      fwdIndex_q <= 8'h00;
      fwdExtAddr_q <= {(PAGE_W+8){1'b0}};
      fwdWrData_q <= 8'h00;
    end
    else if (clkEn)
    begin
      fwdWr_q <= wrReq && !hitLocal;
      fwdRd_q <= rdReq && isSfr && !hitLocal;
      if ((wrReq || (rdReq && isSfr)) && !hitLocal)
      begin
        fwdTarget_q <= target;
        fwdIndex_q <= {areaSel, cpuAddr[6:0]};
        fwdExtAddr_q <= {curPage, cpuAddr};
        fwdWrData_q <= cpuWrData;
      end
    end
  end

  assign cpuBusy = !idle;
  assign cpuRdData = rdData_q;
  assign cpuRdValid = rdValid_q;
  assign sfrAreaSelect = areaSel;
  assign modulePage = curPage;
  assign fwdWr = fwdWr_q;
  assign fwdRd = fwdRd_q;
  assign fwdTarget = fwdTarget_q;
  assign fwdIndex = fwdIndex_q;
  assign fwdExtAddr = fwdExtAddr_q;
  assign fwdWrData = fwdWrData_q;

endmodule // smape_sfr_map
`default_nettype wire

// File: smape_chk_props.sv
// Port checks for the SFR map and page extension block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module smape_chk
#(
  parameter PAGE_W = 3
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [7:0] cpuAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic cpuWrEn,
  input wire logic cpuRdEn,
  input wire logic cpuBusy,
  input wire logic [7:0] cpuRdData,
  input wire logic sfrAreaSelect,
  input wire logic interruptModeBit,
  input wire logic [PAGE_W-1:0] modulePage,
  input wire logic [3:0] fwdTarget,
  input wire logic [7:0] fwdIndex,
  input wire logic [PAGE_W+7:0] fwdExtAddr,
  input wire logic fwdWr,
  input wire logic fwdRd
);
  // ==========================================================
  // Accepted requests
  wire logic go = clkEn && !cpuBusy && (cpuWrEn || cpuRdEn);
  wire logic r8F = go && !cpuWrEn && cpuAddr == 8'h8F;
  wire logic hi = go && cpuAddr[7:6] == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_b2;
    r8F |=> cpuRdData[2];
  endproperty
  a_b2: assert property (p_b2) else $error("bit 2 low");
  property p_rsv;
    r8F |=> cpuRdData == {3'h0, interruptModeBit, 3'h2, sfrAreaSelect};
  endproperty
  a_rsv: assert property (p_rsv) else $error("control read");
  property p_area;
    go && cpuWrEn && cpuAddr == 8'h8F |=> sfrAreaSelect == $past(cpuWrData[0]);
  endproperty
  a_area: assert property (p_area) else $error("area bit");
  property p_std;
    hi && !sfrAreaSelect |=> fwdTarget == 4'h1 && fwdIndex == {1'h0, $past(cpuAddr[6:0])};
  endproperty
  a_std: assert property (p_std) else $error("std area");
  property p_map;
    hi && sfrAreaSelect |=> fwdTarget == 4'h2 && fwdIndex == {1'h1, $past(cpuAddr[6:0])};
  endproperty
  a_map: assert property (p_map) else $error("mapped area");
  property p_fwd;
    hi |=> fwdRd == !$past(cpuWrEn) && fwdWr == $past(cpuWrEn);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward strobe");
  property p_mdu;
    go && cpuAddr[7:3] == 5'h16 |=> (fwdTarget == 4'h4) == $past(sfrAreaSelect);
  endproperty
  a_mdu: assert property (p_mdu) else $error("mdu steering");
  property p_pgd;
    go && !sfrAreaSelect && cpuAddr >= 8'hA2 && cpuAddr <= 8'hA7
      |=> fwdTarget == 4'h8 && fwdExtAddr == {modulePage, $past(cpuAddr)};
  endproperty
  a_pgd: assert property (p_pgd) else $error("paged address");
  property p_pgw;
    go && cpuWrEn && !sfrAreaSelect && cpuAddr == 8'hA1 && cpuWrData[7:6] != 2'h3
      |=> modulePage == $past(cpuWrData[PAGE_W-1:0]);
  endproperty
  a_pgw: assert property (p_pgw) else $error("page load");
endmodule // smape_chk
bind smape_sfr_map smape_chk #(.PAGE_W(PAGE_W)) u_chk (.*);
`default_nettype wire

// File: smape_periph_model.sv
// Peripheral side model answering forwarded reads.
// Assumes read data is wanted in the cycle fwdRd is high.
`timescale 1ns/1ps
`default_nettype none
module smape_periph_model
(
  input wire logic clk,
  input wire logic fwdRd,
  input wire logic [7:0] fwdIndex,
  output logic [7:0] periphRdData
);
  logic [7:0] junk_q = 8'h00;
  always @(posedge clk) junk_q <= junk_q + 8'h1D;
  // Outside a read the bus shows a moving pattern, never stale data
  assign periphRdData = fwdRd ? (fwdIndex ^ 8'h5A) : junk_q;
endmodule // smape_periph_model
`default_nettype wire

// File: tb_smape_sfr_map.sv
// Self-checking bench for the SFR map and page extension block.
// Assumes the bound checker and the peripheral model.
`timescale 1ns/1ps
`default_nettype none
module tb_smape_sfr_map;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic clkEn = 1'h1;
  logic cpuWrEn = 1'h0;
  logic cpuRdEn = 1'h0;
  logic [7:0] cpuAddr = 8'h00;
  logic [7:0] cpuWrData = 8'h00;
  logic cpuBusy, cpuRdValid, sfrAreaSelect, interruptModeBit, fwdWr, fwdRd;
  logic [7:0] cpuRdData, fwdIndex, fwdWrData, periphRdData;
  logic [3:0] fwdTarget;
  logic [2:0] modulePage;
  logic [10:0] fwdExtAddr;
  int miscompares = 0;
  int check_count = 0;
  smape_sfr_map #(.PAGE_W(3)) DUT (.*);
  smape_periph_model u_periph (.clk(clk), .fwdRd(fwdRd), .fwdIndex(fwdIndex), .periphRdData(periphRdData));
  initial forever #2 clk = ~clk;
  // ==========================================================
  // Bus tasks
  task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cpuAddr <= a;
    cpuWrData <= d;
    cpuWrEn <= 1'h1;
    @(posedge clk);
    cpuWrEn <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    @(posedge clk);
    cpuAddr <= a;
    cpuRdEn <= 1'h1;
    @(posedge clk);
    cpuRdEn <= 1'h0;
    #1;
    for (n = 0; n < 4 && cpuRdValid !== 1'h1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("valid", 11'(cpuRdValid), 11'h1);
    chk("data", 11'(cpuRdData), 11'(e));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    int i;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    rd(8'h8F, 8'h04);
    wr(8'h8F, 8'hFF);
    rd(8'h8F, 8'h15);
    wr(8'h8F, 8'h04);
    rd(8'hC5, 8'h1F);
    rd(8'hB3, 8'h69);
    chk("std", 11'(fwdTarget), 11'h1);
    wr(8'hC0, 8'h3C);
    #1;
    chk("wdata", 11'(fwdWrData), 11'h3C);
    chk("fwdwr", 11'(fwdWr), 11'h1);
    wr(8'hA1, 8'h07);
    for (i = 0; i < 4; i++)
    begin
      wr(8'hA1, {2'h2, 2'(i), 1'h0, 3'(i + 1)});
      rd(8'hA1, 8'(i + 1));
    end
    wr(8'hA1, 8'h35);
    rd(8'hA4, 8'h7E);
    chk("ext", fwdExtAddr, {3'h5, 8'hA4});
    for (i = 0; i < 4; i++)
    begin
      wr(8'hA1, {2'h3, 2'(i), 4'h0});
      rd(8'hA1, (i == 0) ? 8'h07 : 8'(i));
    end
    wr(8'h8F, 8'h05);
    rd(8'hC5, 8'h9F);
    rd(8'hB3, 8'hE9);
    chk("mdu", 11'(fwdTarget), 11'h4);
    @(posedge clk);
    clkEn <= 1'h0;
    wr(8'h8F, 8'h04);
    clkEn <= 1'h1;
    rd(8'h8F, 8'h05);
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    rd(8'h8F, 8'h04);
    rd(8'hA1, 8'h00);
    tally_and_finish;
  end
  initial
  begin
    #20000;
    miscompares++;
    tally_and_finish;
  end
endmodule // tb_smape_sfr_map
`default_nettype wire
